/* File: core/pcv_regs.sv */
// Per-channel vendor registers behind the serial management port
// What this block does
// - Output-disable bit puts the channel's pair outputs in high impedance; resets zero.
// - Loopback-disable bit stops transmit enable looping onto carrier sense.
// - Coder-bypass bit skips block encode and decode at 100 Mbps.
// - Whitener-bypass bit skips scrambling and descrambling at 100 Mbps.
// - Shielded-cable bit selects shielded pair cable settings.
// - Squelch-reduce bit selects reduced receive squelch thresholds.
// - Bit 15 shifts first on the serial link, descending, both directions.
// - Polarity-reversed bit follows detected reversed receive polarity; resets zero.
// - Sync-lost bit reads one while the descrambler lost synchronisation.
// - Two-bit channel index returns the addressed channel number.
// - Summary bit reads one when an unmasked status bit changed since last read.
// - Latched no-link bit reads one when no link; resets to one.
// - Speed and duplex flags latch current mode; both reset zero.
// - Bad-symbol flag latches on an invalid code group.
// - Start-delimiter flag latches on data without a start delimiter.
// - End-delimiter flag latches on a stream without end delimiter; resets zero.
// - Mask bits 6..0 suppress interrupts of matching status; reset to one.
// - With interrupt-on-data-line select, pulse data line while idle on pending.
`timescale 1ns/10ps
`default_nettype none
module pcv_regs
  import pcv_pkg::*;
#(
  parameter logic [4:0] PHY_BASE = 5'h00,
  parameter int NCHAN = 4
) (
  sys_clk,
  rstn,
  mgmt_clk,
  mgmt_data_in,
  mgmt_data_out,
  mgmt_data_oe,
  irq_on_mgmt_line,
  pol_reversed_in,
  sync_lost_in,
  cond_in,
  ctrl_out,
  pair_drive_en
);
  input wire logic sys_clk;
  input wire logic rstn;
  input wire logic mgmt_clk;
  input wire logic mgmt_data_in;
  output logic mgmt_data_out;
  output logic mgmt_data_oe;
  input wire logic irq_on_mgmt_line;
  input wire logic [NCHAN-1:0] pol_reversed_in;
  input wire logic [NCHAN-1:0] sync_lost_in;
  input wire pcv_cond_t [NCHAN-1:0] cond_in;
  output pcv_ctrl_t [NCHAN-1:0] ctrl_out;
  output logic [NCHAN-1:0] pair_drive_en;

  if (NCHAN < 1 || NCHAN > 4) begin : g_bad_nchan
    $error("NCHAN must be 1..4");
  end
  if (32'(PHY_BASE) + NCHAN > 32) begin : g_bad_base
    $error("PHY_BASE leaves no room for channels");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = 3 + 2 * NCHAN + 7 * NCHAN;
  logic [SW-1:0] sync_d;
  logic [SW-1:0] sync_q;
  logic mdc_s;
  logic mdi_s;
  logic irq_s;
  logic [NCHAN-1:0] pol_s;
  logic [NCHAN-1:0] los_s;
  pcv_cond_t [NCHAN-1:0] cond_s;

  assign sync_d = {mgmt_clk, mgmt_data_in, irq_on_mgmt_line, pol_reversed_in, sync_lost_in, cond_in};
  assign {mdc_s, mdi_s, irq_s, pol_s, los_s, cond_s} = sync_q;

  pcv_sync #(.W(SW)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(sync_d),
    .q(sync_q)
  );

  // Edge detection on the synchronised management clock
  logic mdc_prev_q;
  logic [1:0] settle_q;
  logic mdc_rise;
  logic mdc_fall;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mdc_prev_q <= 1'b0;
      settle_q <= '0;
    end else begin
      mdc_prev_q <= mdc_s;
      if (settle_q != 2'd3) settle_q <= settle_q + 2'd1;
    end
  end

  // Synchroniser flushes its reset zeros first; a pin idling high must not look like an edge
  assign mdc_rise = mdc_s && !mdc_prev_q && settle_q == 2'd3;
  assign mdc_fall = !mdc_s && mdc_prev_q && settle_q == 2'd3;

  // ----------------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------------
  pcv_state_t state_q;
  logic [5:0] ones_q;
  logic [3:0] hdr_cnt_q;
  logic [13:0] hdr_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] wdata_q;
  logic sel_q;
  logic [1:0] chan_q;
  logic wr_strobe;
  logic rd_strobe;
  logic [1:0] pulse_cnt_q;
  logic [13:0] hdr_next;
  logic hdr_hit;
  logic [4:0] hdr_phy;
  logic [4:0] hdr_reg;
  logic [1:0] hdr_op;
  logic irq_pending;

  assign hdr_next = {hdr_q[12:0], mdi_s};
  assign hdr_op = hdr_next[11:10];
  assign hdr_phy = hdr_next[9:5];
  assign hdr_reg = hdr_next[4:0];
  assign hdr_hit = hdr_next[13:12] == PCV_ST_CODE && (hdr_op == PCV_OP_WR || hdr_op == PCV_OP_RD)
                   && hdr_phy >= PHY_BASE && 32'(hdr_phy) < 32'(PHY_BASE) + NCHAN;

  // Preamble counter: consecutive ones sampled on rising edges
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ones_q <= '0;
    end else if (mdc_rise) begin
      if (!mdi_s) ones_q <= '0;
      else if (ones_q != 6'(PCV_PRE_BITS)) ones_q <= ones_q + 6'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= PCV_IDLE;
      hdr_cnt_q <= '0;
      hdr_q <= '0;
      bit_cnt_q <= '0;
      sel_q <= 1'b0;
      chan_q <= '0;
      wdata_q <= '0;
      pulse_cnt_q <= '0;
    end else begin
      case (state_q)
        PCV_IDLE: begin
          hdr_cnt_q <= '0;
          if (mdc_rise && !mdi_s && ones_q == 6'(PCV_PRE_BITS)) begin
            hdr_q <= {13'h0000, mdi_s};
            hdr_cnt_q <= 4'd1;
            state_q <= PCV_HDR;
          end else if (irq_s && irq_pending && mdc_fall) begin
            pulse_cnt_q <= 2'(PCV_IRQ_PULSE);
            state_q <= PCV_PULSE;
          end
        end
        PCV_HDR: begin
          if (mdc_rise) begin
            hdr_q <= hdr_next;
            hdr_cnt_q <= hdr_cnt_q + 4'd1;
            if (hdr_cnt_q == 4'd13) begin
              sel_q <= hdr_hit && hdr_reg >= PCV_REG_CFG && hdr_reg <= PCV_REG_FACT;
              chan_q <= 2'(hdr_phy - PHY_BASE);
              hdr_q[11:10] <= hdr_op;
              hdr_q[4:0] <= hdr_reg;
              bit_cnt_q <= 5'd1;
              state_q <= PCV_TA;
            end
          end
        end
        PCV_TA: begin
          // Two turnaround bits, then data
          if (mdc_rise) begin
            if (bit_cnt_q == 5'd0) begin
              bit_cnt_q <= 5'd15;
              state_q <= PCV_DATA;
            end else begin
              bit_cnt_q <= bit_cnt_q - 5'd1;
            end
          end
        end
        PCV_DATA: begin
          if (mdc_rise) begin
            wdata_q <= {wdata_q[14:0], mdi_s};
            if (bit_cnt_q == 5'd0) state_q <= PCV_IDLE;
            else bit_cnt_q <= bit_cnt_q - 5'd1;
          end
        end
        PCV_PULSE: begin
          if (mdc_fall) begin
            if (pulse_cnt_q == 2'd1) state_q <= PCV_IDLE;
            pulse_cnt_q <= pulse_cnt_q - 2'd1;
          end
        end
        default: state_q <= PCV_IDLE;
      endcase
    end
  end

  logic is_read;
  logic is_write;
  assign is_read = sel_q && hdr_q[11:10] == PCV_OP_RD;
  assign is_write = sel_q && hdr_q[11:10] == PCV_OP_WR;
  assign wr_strobe = state_q == PCV_DATA && mdc_rise && bit_cnt_q == 5'd0 && is_write;
  // Clear at the capture edge, so no event can slip in between capture and clear
  assign rd_strobe = state_q == PCV_TA && mdc_rise && bit_cnt_q == 5'd1 && is_read
                     && hdr_q[4:0] == PCV_REG_STAT;

  // ----------------------------------------------------------------------
  // Registers per channel
  // ----------------------------------------------------------------------
  logic [NCHAN-1:0][15:0] cfg_q;
  logic [NCHAN-1:0][6:0] mask_q;
  logic [NCHAN-1:0][15:0] fact_q;
  logic [NCHAN-1:0][6:0] latch_q;
  logic [NCHAN-1:0][6:0] held_q;
  logic [NCHAN-1:0][6:0] prev_q;
  logic [NCHAN-1:0] summary_q;
  logic [NCHAN-1:0][15:0] status_word;
  logic [15:0] wfull;

  assign wfull = {wdata_q[14:0], mdi_s};

  function automatic logic wr_hit(input logic [4:0] r, input int ch);
    return wr_strobe && hdr_q[4:0] == r && 32'(chan_q) == ch;
  endfunction

  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    logic [6:0] cur;
    logic [6:0] changed;
    logic rd_this;
    assign cur = cond_s[c];
    assign changed = (cur ^ prev_q[c]) & ~mask_q[c];
    assign rd_this = rd_strobe && 32'(chan_q) == c;

    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        cfg_q[c] <= PCV_CFG_RST;
      end else if (wr_hit(PCV_REG_CFG, c)) begin
        cfg_q[c] <= wfull;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        mask_q[c] <= PCV_MASK_RST[6:0];
      end else if (wr_hit(PCV_REG_MASK, c)) begin
        mask_q[c] <= wfull[6:0];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        fact_q[c] <= PCV_FACT_RST;
      end else if (wr_hit(PCV_REG_FACT, c)) begin
        fact_q[c] <= wfull;
      end
    end

    // Latched flags: hold any event until read, then track live state
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        prev_q[c] <= PCV_LATCH_RST;
        latch_q[c] <= PCV_LATCH_RST;
        held_q[c] <= '0;
      end else begin
        prev_q[c] <= cur;
        if (rd_this) begin
          latch_q[c] <= cur;
          held_q[c] <= cur ^ prev_q[c];
        end else begin
          held_q[c] <= held_q[c] | (cur ^ prev_q[c]);
          latch_q[c] <= (latch_q[c] & held_q[c]) | (cur & ~held_q[c])
                        | (cur & {1'b1, 2'b00, 4'hF});
        end
      end
    end

    // Summary: an event in the read cycle survives the clear
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        summary_q[c] <= 1'b0;
      end else if (|changed) begin
        summary_q[c] <= 1'b1;
      end else if (rd_this) begin
        summary_q[c] <= 1'b0;
      end
    end

    always_comb begin
      status_word[c] = '0;
      status_word[c][PCV_ST_POL] = pol_s[c];
      status_word[c][PCV_ST_SYNC] = los_s[c];
      status_word[c][PCV_ST_CHAN_LO +: 2] = 2'(c);
      status_word[c][PCV_ST_SUMMARY] = summary_q[c];
      status_word[c][6:0] = latch_q[c];
    end

    assign ctrl_out[c] = {cfg_q[c][15:10], cfg_q[c][3:0]};
    assign pair_drive_en[c] = !cfg_q[c][PCV_CFG_HIZ];
  end

  assign irq_pending = |summary_q;

  // ----------------------------------------------------------------------
  // Read data and line drive
  // ----------------------------------------------------------------------
  function automatic logic [15:0] read_word(input logic [4:0] r, input logic [1:0] ch);
    logic [15:0] v;
    v = '0;
    if (r == PCV_REG_CFG) v = cfg_q[ch];
    else if (r == PCV_REG_STAT) v = status_word[ch];
    else if (r == PCV_REG_MASK) v = {9'h000, mask_q[ch]};
    else if (r == PCV_REG_FACT) v = fact_q[ch];
    return v;
  endfunction

  // Read word captured in the turnaround, same edge as the status clear; old values land here
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shift_q <= '0;
    end else if (state_q == PCV_TA && mdc_rise && bit_cnt_q == 5'd1) begin
      shift_q <= read_word(hdr_q[4:0], chan_q);
    end else if (state_q == PCV_DATA && mdc_rise) begin
      shift_q <= {shift_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mgmt_data_out <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end else if (state_q == PCV_PULSE) begin
      mgmt_data_out <= 1'b0;
      mgmt_data_oe <= 1'b1;
    end else if (state_q == PCV_TA && is_read && bit_cnt_q == 5'd0) begin
      mgmt_data_out <= 1'b0;
      mgmt_data_oe <= 1'b1;
    end else if (state_q == PCV_DATA && is_read) begin
      mgmt_data_out <= shift_q[15];
      mgmt_data_oe <= 1'b1;
    end else begin
      mgmt_data_out <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end
  end

endmodule // pcv_regs
`default_nettype wire

/* File: core/pcv_pkg.sv */
// Package: register map, field positions, reset values and frame constants
package pcv_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [4:0] PCV_REG_CFG = 5'h11;
  localparam logic [4:0] PCV_REG_STAT = 5'h12;
  localparam logic [4:0] PCV_REG_MASK = 5'h13;
  localparam logic [4:0] PCV_REG_FACT = 5'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PCV_CFG_HIZ = 15;
  localparam int PCV_CFG_LOOP_OFF = 14;
  localparam int PCV_CFG_BYP_CODER = 13;
  localparam int PCV_CFG_BYP_WHITE = 12;
  localparam int PCV_CFG_SHIELD = 11;
  localparam int PCV_CFG_SQUELCH = 10;
  localparam int PCV_ST_POL = 15;
  localparam int PCV_ST_SYNC = 14;
  localparam int PCV_ST_CHAN_LO = 8;
  localparam int PCV_ST_SUMMARY = 7;

  // ----------------------------------------------------------------------
  // Register and latched-flag reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] PCV_CFG_RST = 16'h0002;
  localparam logic [15:0] PCV_MASK_RST = 16'h007F;
  localparam logic [15:0] PCV_FACT_RST = 16'h0000;
  localparam logic [6:0] PCV_LATCH_RST = 7'h40;

  // ----------------------------------------------------------------------
  // Serial frame constants
  // ----------------------------------------------------------------------
  localparam logic [1:0] PCV_ST_CODE = 2'h1;
  localparam logic [1:0] PCV_OP_WR = 2'h1;
  localparam logic [1:0] PCV_OP_RD = 2'h2;
  localparam int PCV_PRE_BITS = 32;
  localparam int PCV_IRQ_PULSE = 2;

  // Control bits driven out to the channel
  typedef struct packed {
    logic pair_output_hiz;
    logic tx_carrier_loopback_off;
    logic bypass_block_coder;
    logic bypass_whitener;
    logic shielded_cable_sel;
    logic squelch_reduce;
    logic fiber_level_trim_hi;
    logic fiber_level_trim_lo;
    logic edge_time_trim_hi;
    logic edge_time_trim_lo;
  } pcv_ctrl_t;

  // Live status conditions from the channel, order matches bits 6..0
  typedef struct packed {
    logic no_link;
    logic speed_flag;
    logic duplex_flag;
    logic bad_symbol_flag;
    logic missing_start_delim;
    logic missing_end_delim;
    logic babble_flag;
  } pcv_cond_t;

  typedef enum logic [2:0] {
    PCV_IDLE,
    PCV_HDR,
    PCV_TA,
    PCV_DATA,
    PCV_PULSE
  } pcv_state_t;

endpackage : pcv_pkg

/* File: core/pcv_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pcv_sync #(
  parameter int W = 1
) (
  sys_clk,
  rstn,
  d,
  q
);
  input wire logic sys_clk;
  input wire logic rstn;
  input wire logic [W-1:0] d;
  output logic [W-1:0] q;

  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // pcv_sync
`default_nettype wire

/* File: sim/pcv_regs_asserts.sv */
// Checker bound to the vendor register block
`timescale 1ns/10ps
`default_nettype none
module pcv_regs_asserts
  import pcv_pkg::*;
#(
  parameter int NCHAN = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic mgmt_clk,
  input wire logic mgmt_data_in,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe,
  input wire logic irq_on_mgmt_line,
  input wire logic [NCHAN-1:0] pol_reversed_in,
  input wire logic [NCHAN-1:0] sync_lost_in,
  input wire pcv_cond_t [NCHAN-1:0] cond_in,
  input wire pcv_ctrl_t [NCHAN-1:0] ctrl_out,
  input wire logic [NCHAN-1:0] pair_drive_en
);
  localparam int LAG = 10;
  logic clk_q;
  logic [7:0] age_q;
  logic [4:0] rises_q;
  logic [NCHAN-1:0] hiz;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      hiz[i] = ctrl_out[i].pair_output_hiz;
    end
  end
  // Pin is synchronised, so outputs may only move a few cycles after its edge
  always_ff @(posedge sys_clk) begin
    clk_q <= mgmt_clk;
    if (!rstn || mgmt_clk != clk_q) begin
      age_q <= 8'h00;
    end else if (age_q != 8'hFF) begin
      age_q <= age_q + 8'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn || !mgmt_data_oe) begin
      rises_q <= 5'h00;
    end else if (mgmt_clk && !clk_q && rises_q != 5'h1F) begin
      rises_q <= rises_q + 5'h01;
    end
  end
  // ----
  // Checks
  // ----
  sequence s_drive_start;
    $rose(mgmt_data_oe);
  endsequence
  sequence s_edge_recent;
    age_q < 8'(LAG);
  endsequence
  a_reset_ctrl: assert property ($rose(rstn) |-> ctrl_out == {NCHAN{PCV_CFG_RST[15:10], PCV_CFG_RST[3:0]}})
    else $error("config outputs not at reset value");
  a_reset_pins: assert property ($rose(rstn) |-> !mgmt_data_oe && pair_drive_en == {NCHAN{1'b1}})
    else $error("pins not idle after reset");
  a_hiz_follow: assert property (pair_drive_en == ~hiz)
    else $error("pair drive does not follow config");
  a_ctrl_edge: assert property ($changed(ctrl_out) |-> s_edge_recent)
    else $error("config changed away from a clock edge");
  a_oe_edge: assert property (s_drive_start |-> s_edge_recent)
    else $error("drive began away from a clock edge");
  a_data_edge: assert property (mgmt_data_oe && $changed(mgmt_data_out) |-> s_edge_recent)
    else $error("data moved away from a clock edge");
  a_start_low: assert property (s_drive_start |-> !mgmt_data_out)
    else $error("drive did not begin low");
  a_word_len: assert property (mgmt_data_oe |-> rises_q <= 5'h11)
    else $error("drive held past the data word");
endmodule // pcv_regs_asserts
bind pcv_regs pcv_regs_asserts #(.NCHAN(NCHAN)) pcv_regs_asserts_inst (
  .sys_clk(sys_clk), .rstn(rstn), .mgmt_clk(mgmt_clk), .mgmt_data_in(mgmt_data_in),
  .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe), .irq_on_mgmt_line(irq_on_mgmt_line),
  .pol_reversed_in(pol_reversed_in), .sync_lost_in(sync_lost_in), .cond_in(cond_in),
  .ctrl_out(ctrl_out), .pair_drive_en(pair_drive_en)
);
`default_nettype wire

/* File: sim/pcv_mgmt_host.sv */
// Station management controller model driving the management pins
`timescale 1ns/10ps
`default_nettype none
module pcv_mgmt_host
  import pcv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic line,
  output logic mdc,
  output logic drv,
  output logic drv_oe
);
  initial begin
    mdc = 1'b1;
    drv = 1'b1;
    drv_oe = 1'b0;
  end
  // 16 cycles low, 16 high; read bits taken just as the clock rises
  task automatic bit_out(input logic v, input logic en, output logic s);
    @(posedge sys_clk);
    mdc <= 1'b0;
    drv <= v;
    drv_oe <= en;
    repeat (16) @(posedge sys_clk);
    s = line;
    mdc <= 1'b1;
    repeat (15) @(posedge sys_clk);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic en;
    logic s;
    hdr = {PCV_ST_CODE, op, phy, rg};
    en = (op != PCV_OP_RD);
    for (int i = 0; i < PCV_PRE_BITS; i++) begin
      bit_out(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) begin
      bit_out(hdr[i], 1'b1, s);
    end
    bit_out(1'b1, en, s);
    bit_out(1'b0, en, s);
    for (int i = 15; i >= 0; i--) begin
      bit_out(wd[i], en, s);
      rd[i] = s;
    end
    @(posedge sys_clk);
    drv_oe <= 1'b0;
  endtask
  // Clock runs only here and in frames; line left to the pull-up
  task automatic idle(input int n);
    logic s;
    repeat (n) begin
      bit_out(1'b1, 1'b0, s);
    end
  endtask
endmodule // pcv_mgmt_host
`default_nettype wire

/* File: sim/pcv_regs_tb.sv */
// Self-checking bench for the per-channel vendor register block
`timescale 1ns/10ps
`default_nettype none
module pcv_regs_tb
  import pcv_pkg::*;
;
  logic sys_clk;
  logic rstn;
  logic irq_sel;
  logic [3:0] pol;
  logic [3:0] syn;
  pcv_cond_t [3:0] cond;
  pcv_ctrl_t [3:0] ctrl;
  logic [3:0] drive_en;
  logic mdc;
  logic host_d;
  logic host_oe;
  logic dev_d;
  logic dev_oe;
  logic line;
  logic [15:0] rd;
  int fails = 0;
  int n_compared = 0;
  int low_cnt = 0;
  // Pull-up holds the line high when nobody drives it
  assign line = (dev_oe === 1'b1) ? dev_d : ((host_oe === 1'b1) ? host_d : 1'b1);
  pcv_regs pcv_regs_inst (
    .sys_clk(sys_clk), .rstn(rstn), .mgmt_clk(mdc), .mgmt_data_in(line), .mgmt_data_out(dev_d),
    .mgmt_data_oe(dev_oe), .irq_on_mgmt_line(irq_sel), .pol_reversed_in(pol), .sync_lost_in(syn),
    .cond_in(cond), .ctrl_out(ctrl), .pair_drive_en(drive_en)
  );
  pcv_mgmt_host pcv_mgmt_host_inst (
    .sys_clk(sys_clk), .line(line), .mdc(mdc), .drv(host_d), .drv_oe(host_oe)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (dev_oe === 1'b1 && dev_d === 1'b0) low_cnt++;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end
  // ----
  // Helpers
  // ----
  task automatic give_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ctrl(input pcv_ctrl_t [3:0] got, input pcv_ctrl_t [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [4:0] phy, input logic [4:0] rg);
    pcv_mgmt_host_inst.frame(PCV_OP_RD, phy, rg, 16'h0000, rd);
  endtask
  task automatic wr_reg(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    logic [15:0] unused;
    pcv_mgmt_host_inst.frame(PCV_OP_WR, phy, rg, d, unused);
  endtask
  function automatic logic [15:0] stat_exp(input int c, input logic [7:0] low);
    return {pol[c], syn[c], 4'h0, 2'(c), low};
  endfunction
  task automatic pulse(input logic [6:0] ev);
    @(posedge sys_clk);
    cond[0] <= 7'h40 | ev;
    repeat (4) @(posedge sys_clk);
    cond[0] <= 7'h40;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic idle_check(input logic sel, input logic exp);
    int n0;
    @(posedge sys_clk);
    irq_sel <= sel;
    repeat (8) @(posedge sys_clk);
    n0 = low_cnt;
    pcv_mgmt_host_inst.idle(8);
    chk_word({15'h0000, low_cnt != n0}, {15'h0000, exp});
    @(posedge sys_clk);
    irq_sel <= 1'b0;
    pcv_mgmt_host_inst.idle(4);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset_values();
    chk_ctrl(ctrl, {4{10'h002}});
    chk_word({12'h000, drive_en}, 16'h000F);
    rd_reg(5'h00, PCV_REG_CFG);
    chk_word(rd, PCV_CFG_RST);
    rd_reg(5'h00, PCV_REG_MASK);
    chk_word(rd, PCV_MASK_RST);
    rd_reg(5'h03, PCV_REG_FACT);
    chk_word(rd, PCV_FACT_RST);
    for (int c = 0; c < 4; c++) begin
      rd_reg(5'(c), PCV_REG_STAT);
      chk_word(rd, stat_exp(c, 8'h40));
    end
  endtask
  task automatic t_config();
    pcv_ctrl_t [3:0] exp;
    wr_reg(5'h02, PCV_REG_CFG, 16'hA80A);
    wr_reg(5'h01, PCV_REG_CFG, 16'h5405);
    exp = {4{10'h002}};
    exp[2] = 10'h2AA;
    exp[1] = 10'h155;
    chk_ctrl(ctrl, exp);
    chk_word({12'h000, drive_en}, 16'h000B);
    rd_reg(5'h02, PCV_REG_CFG);
    chk_word(rd, 16'hA80A);
    rd_reg(5'h01, PCV_REG_CFG);
    chk_word(rd, 16'h5405);
    wr_reg(5'h02, PCV_REG_CFG, PCV_CFG_RST);
    wr_reg(5'h01, PCV_REG_CFG, PCV_CFG_RST);
    chk_ctrl(ctrl, {4{10'h002}});
    chk_word({12'h000, drive_en}, 16'h000F);
  endtask
  task automatic t_refused();
    rd_reg(5'h04, PCV_REG_CFG);
    chk_word(rd, 16'hFFFF);
    rd_reg(5'h00, 5'h10);
    chk_word(rd, 16'hFFFF);
    wr_reg(5'h05, PCV_REG_CFG, 16'h8000);
    chk_word({12'h000, drive_en}, 16'h000F);
  endtask
  task automatic t_latch();
    wr_reg(5'h00, PCV_REG_MASK, 16'h0077);
    rd_reg(5'h00, PCV_REG_MASK);
    chk_word(rd, 16'h0077);
    pulse(7'h0A);
    rd_reg(5'h00, PCV_REG_STAT);
    chk_word(rd, stat_exp(0, 8'hCA));
    rd_reg(5'h00, PCV_REG_STAT);
    chk_word(rd, stat_exp(0, 8'h40));
    pulse(7'h04);
    rd_reg(5'h00, PCV_REG_STAT);
    chk_word(rd, stat_exp(0, 8'h44));
    @(posedge sys_clk);
    cond[1] <= 7'h70;
    rd_reg(5'h01, PCV_REG_STAT);
    chk_word(rd, stat_exp(1, 8'h70));
  endtask
  task automatic t_irq();
    pulse(7'h08);
    idle_check(1'b0, 1'b0);
    idle_check(1'b1, 1'b1);
    rd_reg(5'h00, PCV_REG_STAT);
    chk_word(rd, stat_exp(0, 8'hC8));
    idle_check(1'b1, 1'b0);
  endtask
  initial begin
    rstn = 1'b0;
    irq_sel = 1'b0;
    pol = 4'b0101;
    syn = 4'b0011;
    cond = {4{7'h40}};
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset_values();
    t_config();
    t_refused();
    t_latch();
    t_irq();
    give_verdict();
  end
endmodule // pcv_regs_tb
`default_nettype wire
